// >>> core/adc_cfg_port.sv
// Implementation choices: register access over APB and the address map.
`include "cfg_defines.svh"
`default_nettype none
module adc_cfg_port
	import cfg_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	cfg_link_if.device       link,
	output logic             pin_only_mode,
	output logic             gain_high,
	output logic             ref_external,
	output logic             fmt_binary,
	output logic             if_cmos,
	output logic             a_buf_off,
	output logic             b_buf_off,
	output logic             a_standby,
	output logic             b_standby,
	output logic             all_down,
	output logic             mux_mode,
	output logic             readout_bit,
	output logic             word_valid,
	output logic [7:0]       word_addr,
	output logic [7:0]       word_data
);

	// ==========================================
	// Input filtering
	localparam int SYNC_W = 11;
	localparam int I_SEL  = 0;
	localparam int I_SCLK = 1;
	localparam int I_DATA = 2;
	localparam int I_RST  = 3;
	localparam int I_PM1  = 4;
	localparam int I_PM2  = 5;
	localparam int I_PM3  = 6;
	localparam int I_SCL0 = 7;
	localparam int I_SEL0 = 9;

	logic [SYNC_W-1:0] raw_w;
	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;
	logic [SYNC_W-1:0] filt_q;
	logic [SYNC_W-1:0] filt_d;

	// All pins come from outside the clock domain
	assign raw_w = {link.sel_level, link.sclk_level,
		link.power_mode_pin_third, link.power_mode_pin_second,
		link.power_mode_pin_first, link.reset_pin,
		link.serial_input_line, link.sclk, link.serial_select_low};

	// Three-stage synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
			assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi]
				: filt_q[gi];
		end
	endgenerate

	// Filtered levels; select idles high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			filt_q <= 11'h001;
		end else begin
			filt_q <= filt_d;
		end
	end

	// ==========================================
	// Mode and shift decoding
	logic        hw_rst_w;
	logic        sel_low_w;
	logic        fall_w;
	logic        take_w;
	logic        commit_w;
	logic [15:0] word_w;
	logic [7:0]  addr_w;
	logic [7:0]  data_w;
	logic        soft_rst_w;
	logic [15:0] shift_q;
	logic [3:0]  cnt_q;
	logic [7:0]  reg_top_q;
	logic [7:0]  reg_pwr_q;

	// Reset pin level: registers held at default, pin mode
	assign hw_rst_w  = filt_q[I_RST];
	assign sel_low_w = ~filt_q[I_SEL] & ~hw_rst_w;
	// Falling shift clock edge, once filtered
	assign fall_w    = filt_q[I_SCLK] & ~filt_d[I_SCLK];
	assign take_w    = sel_low_w & fall_w;
	assign commit_w  = take_w & (cnt_q == `WORD_LAST);
	// Incoming bit enters at the bottom: MSB first
	assign word_w    = {shift_q[14:0], filt_d[I_DATA]};
	assign addr_w    = word_w[`ADDR_MSB:`ADDR_LSB];
	assign data_w    = word_w[`DATA_MSB:0];
	assign soft_rst_w = commit_w & (addr_w == `REG_TOP_ADDR)
		& data_w[`TOP_SOFT_BIT];

	// Bit counter; restarts whenever select is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q   <= 4'h0;
			shift_q <= 16'h0000;
		end else if (!sel_low_w) begin
			cnt_q   <= 4'h0;
			shift_q <= 16'h0000;
		end else if (take_w) begin
			cnt_q   <= cnt_q + 4'h1;
			shift_q <= word_w;
		end
	end

	// Register file; soft reset bit never stays set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_top_q <= `REG_TOP_RST;
			reg_pwr_q <= `REG_PWR_RST;
		end else if (hw_rst_w || soft_rst_w) begin
			reg_top_q <= `REG_TOP_RST;
			reg_pwr_q <= `REG_PWR_RST;
		end else if (commit_w) begin
			if (addr_w == `REG_TOP_ADDR) begin
				reg_top_q <= data_w;
			end
			if (addr_w == `REG_PWR_ADDR) begin
				reg_pwr_q <= data_w;
			end
		end
	end

	// Committed word report
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			word_valid <= 1'b0;
			word_addr  <= 8'h00;
			word_data  <= 8'h00;
		end else begin
			word_valid <= commit_w;
			if (commit_w) begin
				word_addr <= addr_w;
				word_data <= data_w;
			end
		end
	end

	// ==========================================
	// Configuration decoding
	function automatic pwr_type pm_decode(input logic [2:0] m);
		pwr_type p;
		p = '0;
		case (m)
			3'h0: p = '0;
			3'h1: p.a_buf_off = 1'b1;
			3'h2: p.b_buf_off = 1'b1;
			3'h3: begin
				p.a_buf_off = 1'b1;
				p.b_buf_off = 1'b1;
			end
			3'h4: p.all_down  = 1'b1;
			3'h5: p.a_standby = 1'b1;
			3'h6: p.b_standby = 1'b1;
			3'h7: p.mux       = 1'b1;
			default: p = '0;
		endcase
		return p;
	endfunction

	logic       ovrd_w;
	logic [2:0] pm_pins_w;
	logic [2:0] pm_sel_w;
	logic [1:0] sclk_lvl_w;
	logic [1:0] sel_lvl_w;
	pwr_type    pwr_w;
	logic       gain_w;
	logic       ext_w;
	logic       bin_w;
	logic       cmos_w;

	assign sclk_lvl_w = filt_q[I_SCL0+1:I_SCL0];
	assign sel_lvl_w  = filt_q[I_SEL0+1:I_SEL0];
	assign pm_pins_w  = {filt_q[I_PM1], filt_q[I_PM2], filt_q[I_PM3]};
	// Pins rule power modes in pin and combined modes
	assign ovrd_w   = ~hw_rst_w & reg_pwr_q[`PWR_OVRD_BIT];
	assign pm_sel_w = ovrd_w ? reg_pwr_q[`PWR_MODE_MSB:0]
		: pm_pins_w;
	assign pwr_w    = pm_decode(pm_sel_w);

	// Pin mode reads the four-level pins, else registers; binary format is 0 outside pin mode
	assign gain_w = hw_rst_w ? sclk_lvl_w[1]
		: reg_pwr_q[`PWR_GAIN_BIT];
	assign ext_w  = hw_rst_w ? (sclk_lvl_w == `LVL_3_8 ||
		sclk_lvl_w == `LVL_5_8) : reg_pwr_q[`PWR_REF_BIT];
	assign bin_w  = hw_rst_w & (sel_lvl_w == `LVL_3_8 ||
		sel_lvl_w == `LVL_5_8);
	assign cmos_w = hw_rst_w ? sel_lvl_w[1]
		: reg_pwr_q[`PWR_CMOS_BIT];

	// Registered configuration outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_only_mode <= 1'b0;
			gain_high     <= 1'b0;
			ref_external  <= 1'b0;
			fmt_binary    <= 1'b0;
			if_cmos       <= 1'b0;
			a_buf_off     <= 1'b0;
			b_buf_off     <= 1'b0;
			a_standby     <= 1'b0;
			b_standby     <= 1'b0;
			all_down      <= 1'b0;
			mux_mode      <= 1'b0;
			readout_bit   <= 1'b0;
		end else begin
			pin_only_mode <= hw_rst_w;
			gain_high     <= gain_w;
			ref_external  <= ext_w;
			fmt_binary    <= bin_w;
			if_cmos       <= cmos_w;
			a_buf_off     <= pwr_w.a_buf_off;
			b_buf_off     <= pwr_w.b_buf_off;
			a_standby     <= pwr_w.a_standby;
			b_standby     <= pwr_w.b_standby;
			all_down      <= pwr_w.all_down;
			mux_mode      <= pwr_w.mux & cmos_w;
			readout_bit   <= reg_top_q[`TOP_READ_BIT];
		end
	end

endmodule
`default_nettype wire

// >>> core/cfg_defines.svh
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
// ==========================================
// Timing
`define CLK_NS          40
`define RST_PULSE_NS    10
// Least pulse, rounded up, plus margin for the far filter
`define RST_PULSE_CYC   (((`RST_PULSE_NS+`CLK_NS-1)/`CLK_NS)+3)
`define SCLK_MAX_KHZ    20000
// Half period of the made shift clock, cycles of clk_sys
`define SCLK_HALF_CYC   4
// ==========================================
// Serial word layout
`define WORD_LAST       4'hF
`define ADDR_MSB        15
`define ADDR_LSB        8
`define DATA_MSB        7
// ==========================================
// Device registers
`define REG_TOP_ADDR    8'h00
`define REG_PWR_ADDR    8'h14
`define REG_TOP_RST     8'h00
`define REG_PWR_RST     8'h00
`define TOP_SOFT_BIT    1
`define TOP_READ_BIT    0
`define PWR_OVRD_BIT    7
`define PWR_CMOS_BIT    5
`define PWR_GAIN_BIT    4
`define PWR_REF_BIT     3
`define PWR_MODE_MSB    2
// ==========================================
// Four-level analog pin codes
`define LVL_GND         2'h0
`define LVL_3_8         2'h1
`define LVL_5_8         2'h2
`define LVL_FULL        2'h3
// ==========================================
// Controller registers (APB byte addresses)
`define H_CTRL_ADDR     8'h00
`define H_WORD_ADDR     8'h04
`define H_STAT_ADDR     8'h08
`define H_CTRL_RST      13'h0000
`define CTRL_RESET_BIT  0
`define CTRL_START_BIT  1
`define CTRL_PULSE_BIT  2
`define CTRL_PM_LSB     4
`define CTRL_SCLK_LSB   8
`define CTRL_SEL_LSB    10
`endif

// >>> core/cfg_pkg.sv
`default_nettype none
package cfg_pkg;
	// Decoded power and output mode
	typedef struct packed {
		logic a_buf_off;
		logic b_buf_off;
		logic a_standby;
		logic b_standby;
		logic all_down;
		logic mux;
	} pwr_type;

	// Serial controller sequence
	typedef enum {
		H_IDLE,
		H_LEAD,
		H_LOW,
		H_HIGH,
		H_TAIL
	} host_state_type;
endpackage
`default_nettype wire

// >>> core/cfg_link_if.sv
`default_nettype none
// ==========================================
// Pins between controller and converter
interface cfg_link_if;
	logic       reset_pin;
	logic       serial_select_low;
	logic       sclk;
	logic       serial_input_line;
	logic       power_mode_pin_first;
	logic       power_mode_pin_second;
	logic       power_mode_pin_third;
	logic [1:0] sclk_level;
	logic [1:0] sel_level;

	modport device (
		input reset_pin,
		input serial_select_low,
		input sclk,
		input serial_input_line,
		input power_mode_pin_first,
		input power_mode_pin_second,
		input power_mode_pin_third,
		input sclk_level,
		input sel_level
	);

	modport host (
		output reset_pin,
		output serial_select_low,
		output sclk,
		output serial_input_line,
		output power_mode_pin_first,
		output power_mode_pin_second,
		output power_mode_pin_third,
		output sclk_level,
		output sel_level
	);
endinterface
`default_nettype wire

// >>> core/cfg_host.sv
`include "cfg_defines.svh"
`default_nettype none
module cfg_host
	import cfg_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	cfg_link_if.host         link
);

	// ==========================================
	// APB slave
	host_state_type state_q;
	host_state_type state_d;
	logic [12:0] ctrl_q;
	logic [15:0] word_q;
	logic [15:0] sh_q;
	logic [3:0]  bit_q;
	logic [3:0]  div_q;
	logic [3:0]  pulse_q;
	logic        wr_w;
	logic        busy_w;
	logic        start_w;
	logic        tick_w;
	logic        rst_pin_w;
	logic [31:0] rd_w;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_w    = psel & penable & pwrite;
	assign busy_w  = (state_q != H_IDLE);
	assign rst_pin_w = ctrl_q[`CTRL_RESET_BIT] | (pulse_q != 4'h0);
	// Start refused while busy or with reset pin high
	assign start_w = wr_w & (paddr == `H_CTRL_ADDR) & ~busy_w
		& ~rst_pin_w & pwdata[`CTRL_START_BIT];
	assign rd_w = (paddr == `H_CTRL_ADDR) ? {19'h0, ctrl_q}
		: (paddr == `H_WORD_ADDR) ? {16'h0, word_q}
		: (paddr == `H_STAT_ADDR) ? {30'h0, rst_pin_w, busy_w}
		: 32'h0000_0000;

	// Register writes and read data capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q <= `H_CTRL_RST;
			word_q <= 16'h0000;
			prdata <= 32'h0000_0000;
		end else begin
			if (psel && !penable) begin
				prdata <= rd_w;
			end
			if (wr_w && paddr == `H_CTRL_ADDR) begin
				ctrl_q <= pwdata[12:0] & 13'h1FF9;
			end
			if (wr_w && paddr == `H_WORD_ADDR) begin
				word_q <= pwdata[15:0];
			end
		end
	end

	// Timed reset pin pulse
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pulse_q <= 4'h0;
		end else if (wr_w && paddr == `H_CTRL_ADDR &&
			pwdata[`CTRL_PULSE_BIT]) begin
			pulse_q <= 4'(`RST_PULSE_CYC);
		end else if (pulse_q != 4'h0) begin
			pulse_q <= pulse_q - 4'h1;
		end
	end

	// ==========================================
	// Serial word sender
	assign tick_w = (div_q == 4'(`SCLK_HALF_CYC - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			H_IDLE: if (start_w) state_d = H_LEAD;
			H_LEAD: if (tick_w) state_d = H_LOW;
			H_LOW: begin
				if (tick_w) begin
					state_d = (bit_q == `WORD_LAST) ? H_TAIL
						: H_HIGH;
				end
			end
			H_HIGH: if (tick_w) state_d = H_LOW;
			H_TAIL: if (tick_w) state_d = H_IDLE;
			default: state_d = H_IDLE;
		endcase
	end

	// Sequence, divider and shift register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= H_IDLE;
			div_q   <= 4'h0;
			bit_q   <= 4'h0;
			sh_q    <= 16'h0000;
		end else begin
			state_q <= state_d;
			div_q   <= (state_d != state_q) ? 4'h0 : div_q + 4'h1;
			if (start_w) begin
				sh_q  <= word_q;
				bit_q <= 4'h0;
			end else if (state_q == H_LOW && tick_w &&
				bit_q != `WORD_LAST) begin
				sh_q  <= {sh_q[14:0], 1'b0};
				bit_q <= bit_q + 4'h1;
			end
		end
	end

	// Pin drivers; data changes one clk_sys cycle after the rising edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link.reset_pin             <= 1'b0;
			link.serial_select_low     <= 1'b1;
			link.sclk                  <= 1'b1;
			link.serial_input_line     <= 1'b0;
			link.power_mode_pin_first  <= 1'b0;
			link.power_mode_pin_second <= 1'b0;
			link.power_mode_pin_third  <= 1'b0;
			link.sclk_level            <= `LVL_GND;
			link.sel_level             <= `LVL_GND;
		end else begin
			link.reset_pin             <= rst_pin_w;
			link.serial_select_low     <= (state_d == H_IDLE);
			link.sclk                  <= (state_d != H_LOW);
			link.serial_input_line     <= start_w ? word_q[15]
				: sh_q[15];
			link.power_mode_pin_first  <= ctrl_q[`CTRL_PM_LSB+2];
			link.power_mode_pin_second <= ctrl_q[`CTRL_PM_LSB+1];
			link.power_mode_pin_third  <= ctrl_q[`CTRL_PM_LSB];
			link.sclk_level <= ctrl_q[`CTRL_SCLK_LSB+1:`CTRL_SCLK_LSB];
			link.sel_level  <= ctrl_q[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
		end
	end

endmodule
`default_nettype wire

// >>> tb/adc_config_serial_port_assertions.sv
`default_nettype none
module adc_config_serial_port_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reset_pin,
	input wire logic serial_select_low,
	input wire logic sclk,
	input wire logic serial_input_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sclk_q;
	logic [5:0] fall_q;
	logic [5:0] fall_d;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ==========================================
	// Falling shift clock edges within a frame
	assign fall_d = serial_select_low ? 6'h00
		: fall_q + {5'h00, sclk_q & ~sclk};
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b1;
			fall_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			fall_q <= fall_d;
		end
	end

	// ==========================================
	// Link properties
	property p_sclk_idle;
		serial_select_low |-> sclk;
	endproperty
	property p_low_phase;
		$fell(sclk) |-> !sclk [*4] ##1 sclk;
	endproperty
	property p_high_phase;
		$rose(sclk) && !serial_select_low |-> sclk [*4];
	endproperty
	property p_data_hold;
		!sclk |-> $stable(serial_input_line);
	endproperty
	property p_lead;
		$fell(serial_select_low) |-> sclk [*4] ##1 !sclk;
	endproperty
	property p_word_len;
		$rose(serial_select_low) |-> fall_q == 6'h10;
	endproperty
	property p_pulse_width;
		$rose(reset_pin) |-> reset_pin [*3];
	endproperty
	property p_quiet_reset;
		reset_pin |-> serial_select_low;
	endproperty

	a_sclk_idle: assert property (p_sclk_idle)
		else $error("shift clock low outside frame");
	a_low_phase: assert property (p_low_phase)
		else $error("low phase length wrong");
	a_high_phase: assert property (p_high_phase)
		else $error("high phase too short");
	a_data_hold: assert property (p_data_hold)
		else $error("data moved while clock low");
	a_lead: assert property (p_lead)
		else $error("select to first fall wrong");
	a_word_len: assert property (p_word_len)
		else $error("frame not one whole word");
	a_pulse_width: assert property (p_pulse_width)
		else $error("reset pulse too short");
	a_quiet_reset: assert property (p_quiet_reset)
		else $error("frame while reset pin high");

	c_frame: cover property ($rose(serial_select_low) && fall_q == 6'h10);
	c_pulse: cover property ($fell(reset_pin));
	c_level: cover property (reset_pin [*8]);
endmodule
`default_nettype wire

// >>> tb/adc_config_serial_port_tb_top.sv
`default_nettype none
module adc_config_serial_port_tb_top
	import cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, r0, r14, wa, word_addr, word_data;
	logic [31:0] pwdata, prdata, ctrl_v, rd;
	logic [11:0] seen;
	logic [15:0] got[$];
	logic        pin_only_mode, gain_high, ref_external, fmt_binary;
	logic        if_cmos, a_buf_off, b_buf_off, a_standby, b_standby;
	logic        all_down, mux_mode, readout_bit, word_valid;
	int          n_fail, checks_done;

	// ==========================================
	// Both ends across one link
	cfg_link_if link();
	cfg_host cfg_host_i(.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	adc_cfg_port adc_cfg_port_i(.clk_sys(clk_sys), .rst(rst),
		.link(link), .pin_only_mode(pin_only_mode),
		.gain_high(gain_high), .ref_external(ref_external),
		.fmt_binary(fmt_binary), .if_cmos(if_cmos),
		.a_buf_off(a_buf_off), .b_buf_off(b_buf_off),
		.a_standby(a_standby), .b_standby(b_standby),
		.all_down(all_down), .mux_mode(mux_mode),
		.readout_bit(readout_bit), .word_valid(word_valid),
		.word_addr(word_addr), .word_data(word_data));
	adc_config_serial_port_assertions chk_i(.clk_sys(clk_sys),
		.rst(rst), .reset_pin(link.reset_pin),
		.serial_select_low(link.serial_select_low),
		.sclk(link.sclk), .serial_input_line(link.serial_input_line));
	assign seen = {pin_only_mode, gain_high, ref_external, fmt_binary,
		if_cmos, a_buf_off, b_buf_off, a_standby, b_standby,
		all_down, mux_mode, readout_bit};

	// ==========================================
	// Clock, word monitor, watchdog
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (word_valid === 1'b1) got.push_back({word_addr, word_data});
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		$display("unexpected at %0t: timeout", $time);
		end_sim();
	end

	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Expected outputs from pin levels and register model
	function automatic logic [11:0] exp_cfg();
		logic [1:0] sl, el;
		logic [2:0] p;
		logic       g, r, f, c, rp;
		rp = ctrl_v[0];
		sl = ctrl_v[9:8];
		el = ctrl_v[11:10];
		g = rp ? sl[1] : r14[4];
		r = rp ? (sl == 2'h1 || sl == 2'h2) : r14[3];
		f = rp & (el == 2'h1 || el == 2'h2);
		c = rp ? el[1] : r14[5];
		p = (!rp && r14[7]) ? r14[2:0] : ctrl_v[6:4];
		return {rp, g, r, f, c, p == 3'h1 || p == 3'h3,
			p == 3'h2 || p == 3'h3, p == 3'h5, p == 3'h6, p == 3'h4,
			p == 3'h7 && c, !rp && r0[0]};
	endfunction
	task automatic cfg_chk();
		repeat (8) @(posedge clk_sys);
		chk({20'h00000, seen}, {20'h00000, exp_cfg()}, "config");
	endtask
	task automatic pulse();
		apb(1'b1, 8'h00, ctrl_v | 32'h4);
		r0 = 8'h00;
		r14 = 8'h00;
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic send(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, 8'h04, {16'h0000, a, d});
		apb(1'b1, 8'h00, ctrl_v | 32'h2);
		rd = 32'h1;
		for (int i = 0; i < 100 && rd[0] !== 1'b0; i++)
			apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0, "sender still busy");
		if (a == 8'h00) begin
			r0 = d[1] ? 8'h00 : d;
			r14 = d[1] ? 8'h00 : r14;
		end
		if (a == 8'h14) r14 = d;
		repeat (4) @(posedge clk_sys);
		chk(got.size(), 1, "word count");
		if (got.size() > 0)
			chk({16'h0, got.pop_front()}, {16'h0, a, d}, "word");
	endtask
	task automatic end_sim();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h45477716));
		{rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
		{ctrl_v, r0, r14, n_fail, checks_done} = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			ctrl_v = {20'h0, i[3:2], i[1:0], 1'b0, i[4:2], 4'h1};
			apb(1'b1, 8'h00, ctrl_v);
			cfg_chk();
		end
		apb(1'b1, 8'h00, ctrl_v | 32'h2);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h2, "start taken in pin mode");
		$display("test pin_only done");
		ctrl_v = 32'h0;
		apb(1'b1, 8'h00, ctrl_v);
		pulse();
		cfg_chk();
		for (int i = 0; i < 10; i++) begin
			ctrl_v[6:4] = 3'($urandom);
			wa = (i % 2) ? 8'h14 : 8'($urandom);
			if (wa == 8'h00) wa = 8'h01;
			send(wa, 8'($urandom));
			cfg_chk();
		end
		$display("test serial done");
		send(8'h14, 8'hB9);
		send(8'h00, 8'h02);
		cfg_chk();
		send(8'h14, 8'h25);
		cfg_chk();
		$display("test soft_reset done");
		send(8'h00, 8'h01);
		cfg_chk();
		pulse();
		cfg_chk();
		chk(got.size(), 0, "extra words");
		$display("test hard_reset done");
		end_sim();
	end
endmodule
`default_nettype wire
